// File: core/bie_pkg.sv
// Summary of operation
// RULE1: Loop-code enable low blocks loop-code interrupts.
// RULE2: Loop-code interrupt needs block and source enable.
// RULE3: Bit 5 gates the recovered-clock-loss interrupt.
// RULE4: Bit 4 gates the one-second interrupt.
// RULE5: Data-link enable low blocks data-link interrupts.
// RULE6: Data-link interrupt needs block and source enable.
// RULE7: Source status read clears block pending bit.
// RULE8: Enables reset to zero; bit 7 reserved.
`default_nettype none
package bie_pkg;

   // Register indices; byte address is four times the index
   localparam logic [15:0] BIE_IDX_STATUS = 16'h0B00;   // Block pending status
   localparam logic [15:0] BIE_IDX_ENABLE = 16'h0B01;   // Block interrupt enable
   localparam logic [17:0] BIE_ADR_STATUS = {BIE_IDX_STATUS, 2'b00};
   localparam logic [17:0] BIE_ADR_ENABLE = {BIE_IDX_ENABLE, 2'b00};

   // Field positions shared by both registers
   localparam int BIE_BIT_RSVD   = 7;   // Reserved in this mode
   localparam int BIE_BIT_LOOP   = 6;   // Loop-code group
   localparam int BIE_BIT_CLKLOS = 5;   // Recovered clock loss
   localparam int BIE_BIT_ONESEC = 4;   // One-second tick
   localparam int BIE_BIT_LINK   = 3;   // Data-link group
   localparam int BIE_NFLAG      = 4;   // Flags live in bits 6..3
   localparam int BIE_LSB        = 3;

   // Writable enable bits and read-clear status bits
   localparam logic [7:0] BIE_EN_WMASK  = 8'h78;
   localparam logic [7:0] BIE_RC_MASK   = 8'h30;
   localparam logic [7:0] BIE_EN_RESET  = 8'h00;
   localparam logic [7:0] BIE_ST_RESET  = 8'h00;

   // Interrupt path latency from event input to irq, in clock edges
   localparam int BIE_IRQ_LAT = 2;

   // Classic Wishbone request bundle
   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [17:0] adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } bie_wbreq_t;

   // Event inputs from the framer blocks
   typedef struct packed {
      logic loopReq;      // Loop-code request, already source-enabled
      logic loopRead;     // Loop-code source status was read
      logic clkLossEvt;   // Recovered clock loss event pulse
      logic oneSecEvt;    // One-second tick pulse
      logic linkReq;      // Data-link request, already source-enabled
      logic linkRead;     // Data-link source status was read
   } bie_evt_t;

endpackage : bie_pkg
`default_nettype wire

// File: core/bie_flag.sv
`timescale 1ns/1ps
`default_nettype none
// Sticky pending flags; a set in the clear cycle wins
module bie_flag
   import bie_pkg::*;
(
   // Clock and reset
   input  wire logic                 clk_sys,
   input  wire logic                 rstn,
   // Set and clear strobes per flag
   input  wire logic [BIE_NFLAG-1:0] setIn,
   input  wire logic [BIE_NFLAG-1:0] clrIn,
   // Flag state
   output var  logic [BIE_NFLAG-1:0] flagQ
);

   genvar g;

   // One flop per flag
   generate
      for (g = 0; g < BIE_NFLAG; g++) begin : gFlag
         logic flagD;   // Next value
         assign flagD = setIn[g] | (flagQ[g] & ~clrIn[g]);
         always_ff @(posedge clk_sys or negedge rstn) begin
            if (!rstn) begin
               flagQ[g] <= 1'b0;
            end else begin
               flagQ[g] <= flagD;
            end
         end
      end
   endgenerate

endmodule : bie_flag
`default_nettype wire

// File: core/bie_top.sv
`timescale 1ns/1ps
`default_nettype none
// Block interrupt enable, upper half, with its pending status and interrupt pin
module bie_top
   import bie_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rstn,
   // Wishbone slave
   input  wire bie_wbreq_t  wbReq,
   output var  logic        wbAck,
   output var  logic [31:0] wbDatOut,
   // Framer block events
   input  wire bie_evt_t    evt,
   // Interrupt pin, active high level
   output var  logic        irq
);

   // Bus state
   logic        ackQ;        // Registered acknowledge
   logic [31:0] datQ;        // Registered read data
   logic [7:0]  enQ;         // Enable register
   logic [7:0]  enD;         // Enable next value
   logic        irqQ;        // Registered interrupt
   logic        irqD;

   // Decode
   wire         busReq   = wbReq.cyc & wbReq.stb & ~ackQ;
   wire         hitStat  = wbReq.adr == BIE_ADR_STATUS;
   wire         hitEn    = wbReq.adr == BIE_ADR_ENABLE;
   wire         wrEn     = busReq & wbReq.we & hitEn & wbReq.sel[0];
   wire         rdStat   = busReq & ~wbReq.we & hitStat;

   // Pending status bits 6..3
   logic [BIE_NFLAG-1:0] flagQ;
   logic [BIE_NFLAG-1:0] flagSet;
   logic [BIE_NFLAG-1:0] flagClr;
   wire  [7:0]           statQ = {1'b0, flagQ, 3'b000};

   // Loop-code and data-link pending are set by their source requests;
   // the clock-loss and one-second bits are events latched here
   assign flagSet = {evt.loopReq, evt.clkLossEvt, evt.oneSecEvt, evt.linkReq};
   // Group bits clear only when the source status is read
   assign flagClr = {evt.loopRead,                                  // RULE7
                     rdStat, rdStat,
                     evt.linkRead};                                 // RULE7

   bie_flag uFlag (
      .clk_sys (clk_sys),
      .rstn    (rstn),
      .setIn   (flagSet),
      .clrIn   (flagClr),
      .flagQ   (flagQ)
   );

   // Reserved bit 7 and bits 2..0 never store a write
   assign enD = wrEn ? (wbReq.dat[7:0] & BIE_EN_WMASK) : enQ;       // RULE8

   // Block gate and source gate both apply; the request inputs arrive
   // already qualified by their source-level enables
   wire gateLoop = flagQ[BIE_BIT_LOOP-BIE_LSB] & enQ[BIE_BIT_LOOP];      // RULE1 RULE2
   wire gateClk  = flagQ[BIE_BIT_CLKLOS-BIE_LSB] & enQ[BIE_BIT_CLKLOS];  // RULE3
   wire gateSec  = flagQ[BIE_BIT_ONESEC-BIE_LSB] & enQ[BIE_BIT_ONESEC];  // RULE4
   wire gateLink = flagQ[BIE_BIT_LINK-BIE_LSB] & enQ[BIE_BIT_LINK];      // RULE5 RULE6
   assign irqD = gateLoop | gateClk | gateSec | gateLink;

   // Read mux; unmapped addresses read zero
   wire [31:0] rdMux = hitEn   ? {24'h000000, enQ}   :
                       hitStat ? {24'h000000, statQ} : 32'h0000_0000;

   // Enable register, zero from reset
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         enQ <= BIE_EN_RESET;                                        // RULE8
      end else begin
         enQ <= enD;
      end
   end

   // Acknowledge one cycle after the request, dropped the next cycle
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         ackQ <= 1'b0;
         datQ <= 32'h0000_0000;
      end else begin
         ackQ <= busReq;
         // Status snapshot is taken before its read-clear lands
         datQ <= busReq ? rdMux : 32'h0000_0000;
      end
   end

   // Interrupt pin from a flop, so it lags the pending bit one cycle
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         irqQ <= 1'b0;
      end else begin
         irqQ <= irqD;
      end
   end

   // Outputs
   assign wbAck    = ackQ;
   assign wbDatOut = datQ;
   assign irq      = irqQ;

   // Helpers for checks
   wire quiet = !rdStat && !evt.loopRead && !evt.linkRead && !wrEn;

   sequence seqLoopRaise;
      evt.loopReq && enQ[BIE_BIT_LOOP] && quiet;
   endsequence

   sequence seqLinkRaise;
      evt.linkReq && enQ[BIE_BIT_LINK] && quiet;
   endsequence

   sequence seqIrqTwo;
      ##BIE_IRQ_LAT irqQ;
   endsequence

   // Closed loop-code gate, others closed and steady: the pin stays low
   chk_loop_block_gate: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE1
      (!enQ[BIE_BIT_LOOP] && !$past(enQ[BIE_BIT_LOOP]) && enQ[5:3] == 3'b000 && $stable(enQ))
      |-> !irqQ)
      else $error("loop-code interrupt passed a closed block gate");

   // Open loop-code gate passes a qualified request in two edges
   chk_loop_pass_path: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE2
      seqLoopRaise |-> seqIrqTwo)
      else $error("enabled loop-code request did not raise irq");

   // Clock-loss event always latches; the pin then follows its enable
   chk_clk_loss_gate: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE3
      (evt.clkLossEvt && quiet) |=> (flagQ[BIE_BIT_CLKLOS-BIE_LSB]
      ##1 (irqQ || !$past(enQ[BIE_BIT_CLKLOS]))))
      else $error("clock-loss event lost or not gated by its enable");

   // Enabled one-second tick reaches the pin in two edges
   chk_one_sec_gate: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE4
      (evt.oneSecEvt && enQ[BIE_BIT_ONESEC] && quiet) |-> ##2 irqQ)
      else $error("one-second tick did not raise irq");

   // Pin high with the other three closed needs the data-link gate open
   chk_link_block_gate: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE5
      (irqQ && !$past(enQ[6]) && !$past(enQ[5]) && !$past(enQ[4]))
      |-> $past(enQ[BIE_BIT_LINK]))
      else $error("data-link interrupt passed a closed block gate");

   // Open data-link gate passes a qualified request in two edges
   chk_link_pass_path: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE6
      seqLinkRaise |-> seqIrqTwo)
      else $error("enabled data-link request did not raise irq");

   // Loop-code pending drops once its source status was read
   chk_pend_clear_read: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE7
      (evt.loopRead && !evt.loopReq) |=> !flagQ[BIE_BIT_LOOP-BIE_LSB])
      else $error("loop-code pending survived its source read");

   // Enable read-back shows zero in the reserved and lower bits
   chk_rsvd_bit_zero: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE8
      (ackQ && $past(hitEn)) |-> (datQ[7] == 1'b0 && datQ[2:0] == 3'b000))
      else $error("reserved enable bits read nonzero");

   // A held strobe must not stretch the acknowledge
   chk_ack_one_cycle: assert property (@(posedge clk_sys) disable iff (!rstn)
      ackQ |=> !ackQ)
      else $error("acknowledge held longer than one cycle");

   // Data-link source read with no fresh request in the same cycle
   sequence seqLinkClear;
      evt.linkRead && !evt.linkReq;
   endsequence

   // Status read with no clock-loss or one-second event racing it
   sequence seqStatClear;
      rdStat && !evt.clkLossEvt && !evt.oneSecEvt;
   endsequence

   // Data-link pending drops once its source status was read
   chk_link_clear_read: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE7
      seqLinkClear |=> !flagQ[BIE_BIT_LINK-BIE_LSB])
      else $error("data-link pending survived its source read");

   // Reading the status register empties the two event bits
   chk_stat_read_clear: assert property (@(posedge clk_sys) disable iff (!rstn)
      seqStatClear |=> (!flagQ[BIE_BIT_CLKLOS-BIE_LSB] && !flagQ[BIE_BIT_ONESEC-BIE_LSB]))
      else $error("status read left an event bit set");

   // A request in the same cycle as its clear keeps the bit set
   chk_loop_set_wins: assert property (@(posedge clk_sys) disable iff (!rstn)
      evt.loopReq |=> flagQ[BIE_BIT_LOOP-BIE_LSB])
      else $error("loop-code request lost against a clear");

   // Same precedence for the data-link group
   chk_link_set_wins: assert property (@(posedge clk_sys) disable iff (!rstn)
      evt.linkReq |=> flagQ[BIE_BIT_LINK-BIE_LSB])
      else $error("data-link request lost against a clear");

   // With every other enable closed, only the clock-loss gate can drive the pin
   chk_clk_closed_gate: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE3
      (irqQ && !$past(enQ[BIE_BIT_LOOP]) && !$past(enQ[BIE_BIT_ONESEC])
       && !$past(enQ[BIE_BIT_LINK])) |-> $past(enQ[BIE_BIT_CLKLOS]))
      else $error("clock-loss interrupt passed a closed enable");

   // With every other enable closed, only the one-second gate can drive the pin
   chk_sec_closed_gate: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE4
      (irqQ && !$past(enQ[BIE_BIT_LOOP]) && !$past(enQ[BIE_BIT_CLKLOS])
       && !$past(enQ[BIE_BIT_LINK])) |-> $past(enQ[BIE_BIT_ONESEC]))
      else $error("one-second interrupt passed a closed enable");

   // Reserved and lower enable bits can never hold a one
   chk_rsvd_never_set: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE8
      !enQ[BIE_BIT_RSVD] && enQ[BIE_LSB-1:0] == 3'b000)
      else $error("reserved enable bit was stored");

   // An accepted enable write lands at the edge that takes it
   chk_enable_write: assert property (@(posedge clk_sys) disable iff (!rstn)
      wrEn |=> (enQ[BIE_BIT_LOOP:BIE_BIT_LINK]
               == $past(wbReq.dat[BIE_BIT_LOOP:BIE_BIT_LINK])))
      else $error("enable write did not land");

   // Every request is answered at the next edge
   chk_ack_next_edge: assert property (@(posedge clk_sys) disable iff (!rstn)
      busReq |=> ackQ)
      else $error("request was not acknowledged at the next edge");

   // Read data is zero outside the acknowledge cycle
   chk_data_idle_zero: assert property (@(posedge clk_sys) disable iff (!rstn)
      !ackQ |-> (datQ == 32'h0000_0000))
      else $error("read data not zero outside acknowledge");

endmodule : bie_top
`default_nettype wire

// File: tb/bie_host.sv
`timescale 1ns/1ps
`default_nettype none
// Host processor model: classic Wishbone single cycles
module bie_host
   import bie_pkg::*;
(
   // Clock
   input  wire logic        clk_sys,
   // Slave answer
   input  wire logic        wbAck,
   input  wire logic [31:0] wbDatOut,
   // Request bundle
   output var  bie_wbreq_t  wbReq
);
   initial wbReq = '0;   // Idle bus from time zero

   // One transfer; returns the read data and whether the ack was seen
   task automatic xfer(input logic w, input logic [17:0] a, input logic [7:0] d,
                       output logic [31:0] q, output logic ok);
      int n;
      n = 0;
      @(posedge clk_sys);
      wbReq <= {1'b1, 1'b1, w, a, 4'h1, 24'h000000, d};
      // Hold until ack is seen at an edge; bounded so a dead slave cannot hang
      do begin
         @(posedge clk_sys);
         n++;
      end while (wbAck !== 1'b1 && n < 20);
      q = wbDatOut;
      ok = (wbAck === 1'b1);
      wbReq <= '0;   // Release after the acking edge only
   endtask : xfer
endmodule : bie_host
`default_nettype wire

// File: tb/bie_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench for the block interrupt enable
module bie_top_tb
   import bie_pkg::*;
;
   logic        clk_sys = 1'b0;   // 100 MHz system clock
   logic        rstn    = 1'b0;   // Reset, active low
   bie_wbreq_t  wbReq;            // Host request
   logic        wbAck;            // Slave ack
   logic [31:0] wbDatOut;         // Read data
   bie_evt_t    evt     = '0;     // Framer block events
   logic        irq;              // Interrupt pin
   int          n_fail  = 0;      // Mismatches
   int          num_checks = 0;   // Comparisons

   always #5 clk_sys = ~clk_sys;

   bie_top bie_top_inst (.clk_sys(clk_sys), .rstn(rstn), .wbReq(wbReq), .wbAck(wbAck),
                         .wbDatOut(wbDatOut), .evt(evt), .irq(irq));
   bie_host bie_host_inst (.clk_sys(clk_sys), .wbAck(wbAck), .wbDatOut(wbDatOut),
                           .wbReq(wbReq));

   // Verdict and end of run
   task automatic conclude();
      if (n_fail == 0 && num_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : conclude

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // Bus access; a missing ack ends the run as a failure
   task automatic acc(input logic w, input logic [17:0] a, input logic [7:0] d,
                      output logic [31:0] q);
      logic ok;
      bie_host_inst.xfer(w, a, d, q, ok);
      chk("bus ack", 32'h00000001, {31'h0, ok});
      if (!ok) begin
         conclude();
      end
   endtask : acc

   // Let the two-edge interrupt path settle before looking at the pin
   task automatic settle();
      repeat (3) @(posedge clk_sys);
      #1;
   endtask : settle

   task automatic s_reset();
      logic [31:0] q;
      acc(1'b0, BIE_ADR_ENABLE, 8'h00, q);
      chk("enable reset", 32'h00000000, q);
      acc(1'b0, BIE_ADR_STATUS, 8'h00, q);
      chk("status reset", 32'h00000000, q);
      #1;
      chk("irq reset", 32'h00000000, {31'h0, irq});
   endtask : s_reset

   // Reserved bit and unmapped space
   task automatic s_mask();
      logic [31:0] q;
      acc(1'b1, BIE_ADR_ENABLE, 8'hFF, q);
      acc(1'b0, BIE_ADR_ENABLE, 8'h00, q);
      chk("enable rsvd", 32'h00000078, q);
      acc(1'b1, BIE_ADR_STATUS, 8'hFF, q);
      acc(1'b0, BIE_ADR_STATUS, 8'h00, q);
      chk("status write", 32'h00000000, q);
      acc(1'b1, 18'h00010, 8'hFF, q);
      acc(1'b0, 18'h00010, 8'h00, q);
      chk("unmapped", 32'h00000000, q);
      acc(1'b1, BIE_ADR_ENABLE, 8'h00, q);
   endtask : s_mask

   // Source-level enables for clock loss and one-second events
   task automatic s_src(input int b);
      logic [31:0] q;
      logic [7:0]  m;
      m = 8'h01 << b;
      for (int en = 0; en < 2; en++) begin
         acc(1'b1, BIE_ADR_ENABLE, en ? m : 8'h00, q);
         @(posedge clk_sys);
         if (b == BIE_BIT_CLKLOS) evt.clkLossEvt <= 1'b1;
         else evt.oneSecEvt <= 1'b1;
         @(posedge clk_sys);
         evt <= '0;
         settle();
         chk("irq source", {31'h0, en[0]}, {31'h0, irq});
         acc(1'b0, BIE_ADR_STATUS, 8'h00, q);
         chk("status bit", {24'h0, m}, q);
         settle();
         chk("irq cleared", 32'h00000000, {31'h0, irq});
      end
   endtask : s_src

   // Block-level gates for loop-code and data-link groups
   task automatic s_grp(input int b);
      logic [31:0] q;
      @(posedge clk_sys);
      if (b == BIE_BIT_LOOP) evt.loopReq <= 1'b1;
      else evt.linkReq <= 1'b1;
      settle();
      chk("irq gated", 32'h00000000, {31'h0, irq});
      acc(1'b1, BIE_ADR_ENABLE, 8'h01 << b, q);
      settle();
      chk("irq group", 32'h00000001, {31'h0, irq});
      acc(1'b0, BIE_ADR_STATUS, 8'h00, q);
      chk("status pending", {24'h0, 8'h01 << b}, q);
      @(posedge clk_sys);
      if (b == BIE_BIT_LOOP) begin
         evt.loopReq  <= 1'b0;
         evt.loopRead <= 1'b1;
      end else begin
         evt.linkReq  <= 1'b0;
         evt.linkRead <= 1'b1;
      end
      @(posedge clk_sys);
      evt <= '0;
      settle();
      chk("irq serviced", 32'h00000000, {31'h0, irq});
      acc(1'b0, BIE_ADR_STATUS, 8'h00, q);
      chk("status serviced", 32'h00000000, q);
      acc(1'b1, BIE_ADR_ENABLE, 8'h00, q);
   endtask : s_grp

   // Main sequence
   initial begin
      repeat (5) @(posedge clk_sys);
      rstn <= 1'b1;
      s_reset();
      s_mask();
      s_src(BIE_BIT_CLKLOS);
      s_src(BIE_BIT_ONESEC);
      s_grp(BIE_BIT_LOOP);
      s_grp(BIE_BIT_LINK);
      conclude();
   end
endmodule : bie_top_tb
`default_nettype wire
